/* File: sim/edge_capture_timer_assertions.sv */
// Port-level checker of the edge-capture timer.
// Assumes one clock domain; bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module edge_capture_timer_assertions (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic concat_i,
  input wire edge_capture_timer_pkg::timer_cfg_t cfg_a_i,
  input wire edge_capture_timer_pkg::timer_cfg_t cfg_b_i,
  input wire logic [1:0] capture_input_pin_i,
  input wire logic [1:0] load_write_i,
  input wire edge_capture_timer_pkg::status_t [1:0] status_clear_i,
  input wire edge_capture_timer_pkg::status_t [1:0] raw_status_o,
  input wire logic irq_o,
  input wire logic [1:0] dma_req_o,
  input wire logic adc_trigger_o,
  input wire logic [31:0] count_o,
  input wire logic [31:0] capture_o
);
  // ----------------------------------------
  // Relations between ports
  // ----------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Timer A alone in edge count mode
  wire logic cnt_a = cfg_a_i.enable && cfg_a_i.mode == edge_capture_timer_pkg::MODE_EDGE_COUNT && !concat_i;
  wire logic time_a = cfg_a_i.enable && cfg_a_i.mode == edge_capture_timer_pkg::MODE_EDGE_TIME && !concat_i;
  a_edge_count_step: assert property ($past(cnt_a) && !$past(load_write_i[0]) && $changed(count_o[15:0]) |->
    count_o[15:0] == $past(count_o[15:0]) - 16'h1 || count_o[15:0] == cfg_a_i.interval_load)
    else $error("edge count step wrong");
  a_match_reload: assert property (cnt_a && $past(cnt_a) && $rose(raw_status_o[0].match) |->
    count_o[15:0] == cfg_a_i.interval_load) else $error("no reload on match");
  a_full_match: assert property (concat_i && $past(concat_i) && $rose(raw_status_o[0].match) |->
    $past(count_o) == {cfg_b_i.match_value, cfg_a_i.match_value}) else $error("partial 32-bit match");
  a_no_roll_dma: assert property ($past(time_a && count_o[15:0] == 16'h0) &&
    $past(capture_input_pin_i[0]) == $past(capture_input_pin_i[0], 2) |-> !dma_req_o[0])
    else $error("rollover dma");
  a_dma_a_enabled: assert property (dma_req_o[0] |-> $past(cfg_a_i.dma_en)) else $error("dma a unasked");
  a_dma_b_enabled: assert property (dma_req_o[1] |-> $past(cfg_b_i.dma_en && !concat_i))
    else $error("dma b unasked");
  a_irq_masked: assert property (irq_o == |{raw_status_o[0] & cfg_a_i.irq_mask,
    raw_status_o[1] & cfg_b_i.irq_mask}) else $error("irq not from flags");
  a_match_flag_set: assert property (cnt_a && cfg_a_i.edge_sel == edge_capture_timer_pkg::EDGE_RISE &&
    capture_input_pin_i[0] && !$past(capture_input_pin_i[0]) && count_o[15:0] - 16'h1 == cfg_a_i.match_value
    |=> raw_status_o[0].match) else $error("match flag not raised");
  a_flag_sticky: assert property (raw_status_o[0].match && !status_clear_i[0].match |=>
    raw_status_o[0].match) else $error("match flag lost");
  a_adc_interval: assert property (adc_trigger_o |-> $past(cfg_a_i.adc_en && count_o[15:0] == 16'h0) ||
    $past(cfg_b_i.adc_en && count_o[31:16] == 16'h0 && !concat_i)) else $error("adc off interval");
endmodule
`default_nettype wire

/* File: sim/edge_capture_timer_bench.sv */
// Bench of the edge-capture timer: reference counts compared at each result.
// Assumes design, checker and signal source compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module edge_capture_timer_bench;
  logic clock_i, irq, adc;
  logic rst_i = 1'b1;
  logic concat_i = 1'b0;
  edge_capture_timer_pkg::timer_cfg_t cfg [2] = '{default: '0};
  logic [1:0] pin, dma;
  logic [1:0] ld = 2'h0;
  edge_capture_timer_pkg::status_t [1:0] raw;
  edge_capture_timer_pkg::status_t [1:0] clr = '0;
  logic [31:0] cnt, cap;
  logic [31:0] seed = 32'hec85;
  int n_errors = 0;
  int check_count = 0;
  int dma_n [2];
  int adc_n;
  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  edge_capture_timer dut_u (.clock_i(clock_i), .rst_i(rst_i), .concat_i(concat_i), .cfg_a_i(cfg[0]),
    .cfg_b_i(cfg[1]), .capture_input_pin_i(pin), .load_write_i(ld), .status_clear_i(clr),
    .raw_status_o(raw), .irq_o(irq), .dma_req_o(dma), .adc_trigger_o(adc), .count_o(cnt), .capture_o(cap));
  edge_source_model src_u (.clock_i(clock_i), .pin_o(pin));
  // Pulse outputs counted as they stand, one cycle each
  always @(posedge clock_i) begin
    for (int k = 0; k < 2; k++) if (dma[k] === 1'b1) dma_n[k]++;
    if (adc === 1'b1) adc_n++;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // Load pulse; rewritten before every restart since a stale value is not trusted
  task automatic load(input logic [1:0] m);
    ld = m;
    tick(1);
    ld = 2'h0;
    tick(1);
  endtask
  task automatic set(input int ch, input edge_capture_timer_pkg::mode_t md, input logic [15:0] l, mv,
    input logic a);
    cfg[ch] = '{enable: 1'b1, mode: md, edge_sel: edge_capture_timer_pkg::EDGE_RISE, interval_load: l,
      match_value: mv, dma_en: 1'b1, adc_en: a, irq_mask: 3'h4};
    dma_n[ch] = 0;
  endtask
  task automatic clear_all();
    clr = '1;
    tick(1);
    clr = '0;
    tick(1);
  endtask
  task automatic tally_and_finish();
    $display("TB: %0d checks, %0d mismatches", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  // Reference model walks each edge: step down, reload on reaching the match
  task automatic edge_count(input int ch);
    int c, m, n;
    c = 5;
    m = 0;
    set(ch, edge_capture_timer_pkg::MODE_EDGE_COUNT, 16'h5, 16'h2, 1'b0);
    load(2'(1 << ch));
    repeat (3) begin
      n = 1 + int'(xs() % 5);
      src_u.pulses(ch, n);
      for (int i = 0; i < n; i++) begin
        c = (c - 1 == 2) ? 5 : c - 1;
        m += (c == 5);
      end
      tick(3);
      `CHK("count", 16'(c), cnt[16*ch +: 16])
      `CHK("dma", m, dma_n[ch])
    end
    `CHK("match", 1'b1, raw[ch].match)
    `CHK("irq", 1'b1, irq)
    clr[ch].match = 1'b1;
    tick(1);
    clr = '0;
    tick(1);
    `CHK("cleared", 1'b0, raw[ch].match)
    cfg[ch].enable = 1'b0;
    $display("edge count on timer %0d done", ch);
  endtask
  initial begin
    tick(16);
    rst_i = 1'b0;
    for (int ch = 0; ch < 2; ch++) edge_count(ch);
    // Rollovers in edge time mode with DMA left on; only the edge may request
    clear_all();
    set(0, edge_capture_timer_pkg::MODE_EDGE_TIME, 16'h13, 16'h0, 1'b0);
    load(2'h1);
    tick(45);
    `CHK("timeout", 1'b1, raw[0].timeout)
    `CHK("roll dma", 0, dma_n[0])
    // Requests masked across the next terminal count, as software may do
    cfg[0].dma_en = 1'b0;
    tick(15);
    cfg[0].dma_en = 1'b1;
    src_u.pulses(0, 1);
    tick(2);
    `CHK("capture dma", 1, dma_n[0])
    `CHK("capture", 1'b1, raw[0].capture)
    // Period 20 from a load of 19; edge seen 63 edges after the load
    `CHK("capture value", 16'(19 - 62 % 20), cap[15:0])
    $display("edge time done");
    // Chained pair: low half passes its match first, only the full match fires
    clear_all();
    concat_i = 1'b1;
    set(1, edge_capture_timer_pkg::MODE_PERIODIC, 16'h1, 16'h2, 1'b0);
    set(0, edge_capture_timer_pkg::MODE_PERIODIC, 16'h6, 16'h3, 1'b0);
    load(2'h1);
    tick(8);
    `CHK("half match", 1'b0, raw[0].match)
    cfg[1].interval_load = 16'h0;
    cfg[1].match_value = 16'h0;
    load(2'h1);
    tick(8);
    `CHK("full match", 1'b1, raw[0].match)
    `CHK("full dma", 1, dma_n[0])
    concat_i = 1'b0;
    $display("chained match done");
    // ADC from timer A every ten cycles while timer B runs its own period
    set(0, edge_capture_timer_pkg::MODE_PERIODIC, 16'h9, 16'h0, 1'b1);
    set(1, edge_capture_timer_pkg::MODE_PERIODIC, 16'h3, 16'h0, 1'b0);
    load(2'h3);
    tick(5);
    adc_n = 0;
    tick(100);
    `CHK("adc", 10, adc_n)
    $display("adc interval done");
    tally_and_finish();
  end
  // Watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (2000) @(posedge clock_i);
    n_errors++;
    tally_and_finish();
  end
endmodule
bind edge_capture_timer edge_capture_timer_assertions chk_u (.clock_i(clock_i), .rst_i(rst_i),
  .concat_i(concat_i), .cfg_a_i(cfg_a_i), .cfg_b_i(cfg_b_i), .capture_input_pin_i(capture_input_pin_i),
  .load_write_i(load_write_i), .status_clear_i(status_clear_i), .raw_status_o(raw_status_o), .irq_o(irq_o),
  .dma_req_o(dma_req_o), .adc_trigger_o(adc_trigger_o), .count_o(count_o), .capture_o(capture_o));
`default_nettype wire

/* File: sim/edge_source_model.sv */
// Signal source on the two capture pins; idles low between pulses.
// Assumes pulses launch on falling edges of the bench clock.
`timescale 1ns/1ps
`default_nettype none
module edge_source_model (
  input wire logic clock_i,
  output logic [1:0] pin_o
);
  // Idle low so no stray edge reaches the timer
  initial pin_o = 2'h0;
  // One rise and one fall per pulse, a cycle apart
  task automatic pulses(input int ch, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clock_i) pin_o[ch] = 1'b1;
      @(negedge clock_i) pin_o[ch] = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: src/edge_capture_timer.sv */
// Two 16-bit capture timers, optionally chained as one 32-bit timer.
// Assumes capture pins and configuration are synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "edge_capture_timer_regs.svh"

module edge_capture_timer (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic concat_i,
  input wire edge_capture_timer_pkg::timer_cfg_t cfg_a_i,
  input wire edge_capture_timer_pkg::timer_cfg_t cfg_b_i,
  input wire logic [1:0] capture_input_pin_i,
  input wire logic [1:0] load_write_i,
  input wire edge_capture_timer_pkg::status_t [1:0] status_clear_i,
  output var edge_capture_timer_pkg::status_t [1:0] raw_status_o,
  output logic irq_o,
  output logic [1:0] dma_req_o,
  output logic adc_trigger_o,
  output logic [31:0] count_o,
  output logic [31:0] capture_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  edge_capture_timer_pkg::timer_cfg_t cfg [2];
  edge_capture_timer_pkg::status_t [1:0] status_reg;
  edge_capture_timer_pkg::status_t [1:0] status_next;
  edge_capture_timer_pkg::status_t [1:0] set16;
  edge_capture_timer_pkg::status_t [1:0] set_final;
  logic [15:0] cnt_reg [2];
  logic [15:0] cnt16_next [2];
  logic [15:0] cap_reg [2];
  logic [1:0] run_reg;
  logic [1:0] run16_next;
  logic [1:0] pin_q_reg;
  logic [1:0] edge_hit;
  logic [1:0] adc16;
  logic [1:0] dma_reg;
  logic adc_reg;

  // Indexable copies so the generate loop can pick its own timer
  assign cfg[0] = cfg_a_i;
  assign cfg[1] = cfg_b_i;

  // ----------------------------------------
  // Per-timer 16-bit logic
  // ----------------------------------------
  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_tmr
      // Edge sense against last cycle's pin; mode decode for this timer
      wire logic rise = capture_input_pin_i[t] & ~pin_q_reg[t];
      wire logic fall = ~capture_input_pin_i[t] & pin_q_reg[t];
      wire logic is_cnt = cfg[t].mode == edge_capture_timer_pkg::MODE_EDGE_COUNT;
      wire logic is_time = cfg[t].mode == edge_capture_timer_pkg::MODE_EDGE_TIME;
      wire logic is_one = cfg[t].mode == edge_capture_timer_pkg::MODE_ONE_SHOT;
      wire logic is_per = cfg[t].mode == edge_capture_timer_pkg::MODE_PERIODIC || is_one;

      // Counter arithmetic and compare terms
      wire logic [15:0] dec = cnt_reg[t] - 16'h0001;
      wire logic zero = cnt_reg[t] == 16'h0000;
      wire logic tick = cfg[t].enable & (is_time | (is_per & run_reg[t]));
      wire logic ev_match = is_cnt & edge_hit[t] & (dec == cfg[t].match_value);
      wire logic per_match = is_per & tick & (cnt_reg[t] == cfg[t].match_value);
      wire logic timeout = tick & zero & ~load_write_i[t];
      logic [15:0] nxt;
      logic run_nxt;

      // Edge qualifier from the chosen polarity
      assign edge_hit[t] = cfg[t].enable & (
        cfg[t].edge_sel == edge_capture_timer_pkg::EDGE_RISE ? rise :
        cfg[t].edge_sel == edge_capture_timer_pkg::EDGE_FALL ? fall : (rise | fall));

      // Load write restarts; events step edge-count mode; clock steps edge-time and timed modes
      always_comb begin
        nxt = cnt_reg[t];
        run_nxt = run_reg[t];
        if (load_write_i[t]) begin
          nxt = cfg[t].interval_load;
          run_nxt = 1'b1;
        end else if (is_cnt & edge_hit[t]) begin
          nxt = ev_match ? cfg[t].interval_load : dec;
        end else if (tick) begin
          nxt = zero ? cfg[t].interval_load : dec;
          if (zero & is_one) begin
            run_nxt = 1'b0;
          end
        end
      end

      // Per-timer results; the chained path may still override them
      assign cnt16_next[t] = nxt;
      assign run16_next[t] = run_nxt;
      assign set16[t].match = ev_match | per_match;
      assign set16[t].capture = is_time & edge_hit[t];
      assign set16[t].timeout = timeout;
      assign adc16[t] = cfg[t].adc_en & is_per & timeout;
    end
  endgenerate

  // ----------------------------------------
  // Chained 32-bit timer on Timer A controls
  // ----------------------------------------
  // Timer B lends only its upper halves; its own mode is ignored
  wire logic [31:0] cnt32 = {cnt_reg[1], cnt_reg[0]};
  wire logic [31:0] load32 = {cfg_b_i.interval_load, cfg_a_i.interval_load};
  wire logic [31:0] match32 = {cfg_b_i.match_value, cfg_a_i.match_value};
  wire logic [31:0] dec32 = cnt32 - 32'h0000_0001;
  wire logic zero32 = cnt32 == 32'h0000_0000;
  wire logic one32 = cfg_a_i.mode == edge_capture_timer_pkg::MODE_ONE_SHOT;
  wire logic per32 = cfg_a_i.mode == edge_capture_timer_pkg::MODE_PERIODIC || one32;
  wire logic tick32 = cfg_a_i.enable & per32 & run_reg[0];
  // Full-width compare: a low-half hit alone must not fire
  wire logic match32_hit = tick32 & (cnt32 == match32);
  wire logic timeout32 = tick32 & zero32 & ~load_write_i[0];
  logic [31:0] cnt32_next;
  logic run32_next;

  // Chained counter next value; only periodic and one-shot make sense here
  always_comb begin
    cnt32_next = cnt32;
    run32_next = run_reg[0];
    if (load_write_i[0]) begin
      cnt32_next = load32;
      run32_next = 1'b1;
    end else if (tick32) begin
      cnt32_next = zero32 ? load32 : dec32;
      if (zero32 & one32) begin
        run32_next = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Event selection between 16-bit and chained
  // ----------------------------------------
  // Chained mode takes over Timer A's flags
  assign set_final[0] = concat_i ? {match32_hit, 1'b0, timeout32} : set16[0];
  assign set_final[1] = concat_i ? 3'h0 : set16[1]; // Timer B idle when chained

  // Set beats a same-cycle clear so no event is lost
  assign status_next[0] = set_final[0] | (status_reg[0] & ~status_clear_i[0]);
  assign status_next[1] = set_final[1] | (status_reg[1] & ~status_clear_i[1]);

  // DMA on match or capture only; rollover timeout is kept off the request
  wire logic [1:0] dma_next = {
    cfg_b_i.dma_en & (set_final[1].match | set_final[1].capture),
    cfg_a_i.dma_en & (set_final[0].match | set_final[0].capture)};

  // Each timer triggers only from its own timeout, never from its neighbour
  wire logic adc_next = concat_i ? (cfg_a_i.adc_en & timeout32) : (|adc16);

  // ----------------------------------------
  // Counters and run flags
  // ----------------------------------------
  // Pin history resets low so an idle-low pin gives no false edge
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg[0] <= `TMR_CNT_RESET;
      cnt_reg[1] <= `TMR_CNT_RESET;
      run_reg <= `TMR_RUN_RESET;
      pin_q_reg <= `TMR_PIN_RESET;
    end else begin
      cnt_reg[0] <= concat_i ? cnt32_next[15:0] : cnt16_next[0];
      cnt_reg[1] <= concat_i ? cnt32_next[31:16] : cnt16_next[1];
      run_reg <= concat_i ? {1'b0, run32_next} : run16_next;
      pin_q_reg <= capture_input_pin_i;
    end
  end

  // ----------------------------------------
  // Capture latches for edge-time mode
  // ----------------------------------------
  // Keeps the pre-edge count; a later edge overwrites it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cap_reg[0] <= `TMR_CAP_RESET;
      cap_reg[1] <= `TMR_CAP_RESET;
    end else begin
      if (set_final[0].capture) begin
        cap_reg[0] <= cnt_reg[0];
      end
      if (set_final[1].capture) begin
        cap_reg[1] <= cnt_reg[1];
      end
    end
  end

  // ----------------------------------------
  // Status, DMA and ADC pulses
  // ----------------------------------------
  // Registered so DMA and ADC see clean one-cycle strobes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= `TMR_STATUS_RESET;
      dma_reg <= `TMR_DMA_RESET;
      adc_reg <= `TMR_ADC_RESET;
    end else begin
      status_reg <= status_next;
      dma_reg <= dma_next;
      adc_reg <= adc_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Mask gates only the interrupt; raw flags stay visible regardless
  wire logic irq_a = |(status_reg[0] & cfg_a_i.irq_mask);
  wire logic irq_b = |(status_reg[1] & cfg_b_i.irq_mask);
  assign irq_o = irq_a | irq_b;
  assign raw_status_o = status_reg;
  assign dma_req_o = dma_reg;
  assign adc_trigger_o = adc_reg;
  // Count and capture come straight from flip-flops
  assign count_o = cnt32;
  assign capture_o = {cap_reg[1], cap_reg[0]};

endmodule
`default_nettype wire

/* File: src/edge_capture_timer_pkg.sv */
// Types shared by the edge-capture timer and its bench.
// Assumes the constants header sits beside it in src/.
`include "edge_capture_timer_regs.svh"

package edge_capture_timer_pkg;

  // ----------------------------------------
  // Modes and edge selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_PERIODIC = 2'h0,
    MODE_ONE_SHOT = 2'h1,
    MODE_EDGE_COUNT = 2'h3,
    MODE_EDGE_TIME = 2'h2
  } mode_t;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h3
  } edge_sel_t;

  // ----------------------------------------
  // Per-timer configuration and status
  // ----------------------------------------
  typedef struct packed {
    logic enable;
    mode_t mode;
    edge_sel_t edge_sel;
    logic [`TMR_HALF_W-1:0] interval_load;
    logic [`TMR_HALF_W-1:0] match_value;
    logic dma_en;
    logic adc_en;
    logic [2:0] irq_mask;
  } timer_cfg_t;

  typedef struct packed {
    logic match;
    logic capture;
    logic timeout;
  } status_t;

endpackage

/* File: src/edge_capture_timer_regs.svh */
// Constants of the edge-capture timer: reset values and widths.
// Assumes inclusion from the timer package and the timer module only.
//
// What this block does
// - Edge-count mode: each qualifying capture pin event decrements the counter toward the match value.
// - On reaching the match value: raise interrupt, reload from load value, keep counting.
// - 32-bit mode: match interrupt and DMA fire only on a full 32-bit match.
// - Edge-time mode: timer rollover at terminal count raises no DMA request.
// - Timer A and Timer B both raise DMA requests in edge-count and edge-time modes.
// - ADC trigger comes only from its own timer's interval; chained, from the 32-bit timeout gated by Timer A's adc_en.
`ifndef EDGE_CAPTURE_TIMER_REGS_SVH
`define EDGE_CAPTURE_TIMER_REGS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define TMR_HALF_W 16
`define TMR_FULL_W 32
`define TMR_COUNT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TMR_CNT_RESET 16'hffff
`define TMR_CAP_RESET 16'h0000
`define TMR_PIN_RESET 2'h0
`define TMR_RUN_RESET 2'h0
`define TMR_STATUS_RESET 6'h00
`define TMR_DMA_RESET 2'h0
`define TMR_ADC_RESET 1'b0

`endif
